// >>> common/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int             ADDR_W              = 12;
	localparam int             REG_W               = 8;
	localparam logic [11:0]    CAL_INIT_CODE_ADDR  = 12'h0ed;
	localparam logic [11:0]    SAMPLE_FORMAT_ADDR  = 12'h110;
	localparam logic [11:0]    FEATURE_CTRL_ADDR   = 12'h111;

	// ************************************************************
	// reset values and calibration go code
	// ************************************************************
	localparam logic [7:0]     CAL_INIT_CODE_RST   = 8'ha6;
	localparam logic [7:0]     CAL_INIT_CODE_GO    = 8'ha2;
	localparam logic           OFFSET_BINARY_RST   = 1'h0;
	localparam logic           INVERSE_SINC_RST    = 1'h1;
	localparam logic           DIGITAL_GAIN_RST    = 1'h1;
	localparam logic           PHASE_COMP_RST      = 1'h0;
	localparam logic           NEG_SIDEBAND_RST    = 1'h0;
	localparam logic           ROUTE_RST           = 1'h0;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int             OFFSET_BINARY_BIT   = 7;
	localparam int             INVERSE_SINC_BIT    = 7;
	localparam int             DIGITAL_GAIN_BIT    = 5;
	localparam int             PHASE_COMP_BIT      = 4;
	localparam int             MOD_SEL_HI          = 3;
	localparam int             MOD_SEL_LO          = 2;
	localparam int             NEG_SIDEBAND_BIT    = 1;
	localparam int             ROUTE_BIT           = 0;

	// ************************************************************
	// modulation modes and register select codes
	// ************************************************************
	typedef enum logic [1:0] {
		MOD_NONE   = 2'h0,
		MOD_FINE   = 2'h1,
		MOD_FS_4   = 2'h2,
		MOD_FS_8   = 2'h3
	} mod_sel_t;

	localparam mod_sel_t       MOD_SEL_RST         = MOD_NONE;

	typedef enum logic [1:0] {
		REG_CAL_INIT,
		REG_FORMAT,
		REG_FEATURE,
		REG_NONE
	} reg_sel_t;

endpackage : dac_ctrl_pkg

// >>> common/dp_ctrl_if.sv
`timescale 1ns/1ps
interface dp_ctrl_if;
	import dac_ctrl_pkg::*;

	logic       offset_binary;
	logic       inphase_to_quad_route;
	logic       neg_sideband;
	mod_sel_t   mod_sel;

	modport regs  (output offset_binary, output inphase_to_quad_route,
		output neg_sideband, output mod_sel);
	modport stage (input offset_binary, input inphase_to_quad_route,
		input neg_sideband, input mod_sel);
endinterface : dp_ctrl_if

// >>> logic/dp_tail_stage.sv
`timescale 1ns/1ps
module dp_tail_stage
	import dac_ctrl_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int TW_W     = 48
) (
	input  wire logic                clock,
	input  wire logic                rst_b,
	dp_ctrl_if.stage                 ctrl,
	input  wire logic                in_valid,
	input  wire logic [SAMPLE_W-1:0] in_i,
	input  wire logic [SAMPLE_W-1:0] in_q,
	input  wire logic [TW_W-1:0]     tw_in,
	output logic                     out_valid,
	output logic      [SAMPLE_W-1:0] out_i,
	output logic      [SAMPLE_W-1:0] out_q,
	output logic      [TW_W-1:0]     tw_out
);

	// ************************************************************
	// format conversion to internal twos complement
	// ************************************************************
	logic [SAMPLE_W-1:0] conv_i;
	logic [SAMPLE_W-1:0] conv_q;
	logic [SAMPLE_W-1:0] msb_flip;

	// offset binary differs from twos complement only in the sign bit
	assign msb_flip = {ctrl.offset_binary, {(SAMPLE_W-1){1'b0}}}; // (RULE3)
	assign conv_i   = in_i ^ msb_flip;                            // (RULE3)
	assign conv_q   = in_q ^ msb_flip;                            // (RULE3)

	// ************************************************************
	// output stage, last point before the converters
	// ************************************************************
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			out_valid <= 1'b0;
			out_i     <= '0;
			out_q     <= '0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				out_i <= conv_i;
				out_q <= ctrl.inphase_to_quad_route ? conv_i : conv_q; // (RULE9)
			end
		end
	end

	// ************************************************************
	// tuning word sign for sideband selection
	// ************************************************************
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tw_out <= '0;
		end else if (ctrl.neg_sideband && ctrl.mod_sel == MOD_FINE) begin
			tw_out <= TW_W'(~tw_in + 1'b1); // (RULE8)
		end else begin
			tw_out <= tw_in;
		end
	end

endmodule : dp_tail_stage

// >>> logic/dac_datapath_control_regs.sv
// Overview of operation
// (RULE1) Software loads the calibration init code with 0xa2 before any calibration run.
// (RULE2) The calibration init code is an 8-bit read/write register resetting to 0xa6.
// (RULE3) Format bit 7 low means twos complement samples, high means offset binary; reset 0.
// (RULE4) Feature bit 7 enables the inverse sinc filter and resets to 1.
// (RULE5) Feature bit 5 enables the digital gain stage and resets to 1.
// (RULE6) Feature bit 4 enables phase compensation and resets to 0.
// (RULE7) Feature bits 3:2 pick none, fine, fs/4 coarse or fs/8 coarse modulation; reset 00.
// (RULE8) Feature bit 1 negates the tuning word, only while fine modulation is selected.
// (RULE9) Feature bit 0 sends in-phase data into the quadrature path at the datapath end.
// (RULE10) The calibration enable must stay high for coefficients to be applied.
// (RULE11) A rising edge of the calibration start bit launches calibration of the paged converters.
// (RULE12) Reserved bits of format and feature registers read zero and ignore writes.
`timescale 1ns/1ps
module dac_datapath_control_regs
	import dac_ctrl_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int TW_W     = 48,
	parameter int PAGE_W   = 4
) (
	input  wire logic                CLOCK,
	input  wire logic                RST_B,
	input  wire logic [ADDR_W-1:0]   REG_ADDR,
	input  wire logic                REG_WR,
	input  wire logic [REG_W-1:0]    REG_WDATA,
	input  wire logic                REG_RD,
	output logic      [REG_W-1:0]    REG_RDATA,
	output logic                     REG_RVALID,
	input  wire logic                CAL_ENABLE_BIT,
	input  wire logic                CAL_START_BIT,
	input  wire logic [PAGE_W-1:0]   CAL_PAGE,
	output logic                     CAL_LAUNCH,
	output logic      [PAGE_W-1:0]   CAL_LAUNCH_PAGE,
	output logic                     CAL_COEFF_APPLY,
	output logic                     CAL_INIT_READY,
	output logic      [REG_W-1:0]    CAL_INIT_VALUE,
	output logic                     INVERSE_SINC_ON,
	output logic                     DIGITAL_GAIN_ON,
	output logic                     PHASE_COMP_ON,
	output logic      [1:0]          MOD_SELECT,
	input  wire logic                SAMPLE_VALID,
	input  wire logic [SAMPLE_W-1:0] SAMPLE_I,
	input  wire logic [SAMPLE_W-1:0] SAMPLE_Q,
	input  wire logic [TW_W-1:0]     TUNING_WORD,
	output logic                     DAC_VALID,
	output logic      [SAMPLE_W-1:0] DAC_I,
	output logic      [SAMPLE_W-1:0] DAC_Q,
	output logic      [TW_W-1:0]     TUNING_WORD_EFF
);

	// ************************************************************
	// address decode
	// ************************************************************
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
		unique case (addr)
			CAL_INIT_CODE_ADDR: decode = REG_CAL_INIT;
			SAMPLE_FORMAT_ADDR: decode = REG_FORMAT;
			FEATURE_CTRL_ADDR:  decode = REG_FEATURE;
			default:            decode = REG_NONE;
		endcase
	endfunction : decode

	dp_ctrl_if   ctrl ();

	logic [7:0]  cal_init_code;
	logic        offset_binary;
	logic        inverse_sinc_on;
	logic        digital_gain_on;
	logic        phase_comp_on;
	mod_sel_t    mod_sel;
	logic        neg_sideband;
	logic        inphase_to_quad_route;
	logic        start_prev;
	reg_sel_t    wr_sel;
	reg_sel_t    rd_sel;
	logic [7:0]  format_word;
	logic [7:0]  feature_word;

	assign wr_sel = decode(REG_ADDR);
	assign rd_sel = decode(REG_ADDR);

	// ************************************************************
	// write strobes, one per register
	// ************************************************************
	logic        wr_cal_init;
	logic        wr_format;
	logic        wr_feature;

	assign wr_cal_init = REG_WR && (wr_sel == REG_CAL_INIT);
	assign wr_format   = REG_WR && (wr_sel == REG_FORMAT);
	assign wr_feature  = REG_WR && (wr_sel == REG_FEATURE);

	// ************************************************************
	// register writes
	// ************************************************************
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			cal_init_code <= CAL_INIT_CODE_RST; // (RULE2)
		end else if (wr_cal_init) begin
			cal_init_code <= REG_WDATA; // (RULE2)
		end
	end

	// reserved bits hold no storage, so writes to them vanish
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			offset_binary <= OFFSET_BINARY_RST;
		end else if (wr_format) begin
			offset_binary <= REG_WDATA[OFFSET_BINARY_BIT]; // (RULE3) (RULE12)
		end
	end

	// every field is taken at once, so software does read-modify-write
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			inverse_sinc_on       <= INVERSE_SINC_RST;
			digital_gain_on       <= DIGITAL_GAIN_RST;
			phase_comp_on         <= PHASE_COMP_RST;
			mod_sel               <= MOD_SEL_RST;
			neg_sideband          <= NEG_SIDEBAND_RST;
			inphase_to_quad_route <= ROUTE_RST;
		end else if (wr_feature) begin
			inverse_sinc_on       <= REG_WDATA[INVERSE_SINC_BIT];          // (RULE4)
			digital_gain_on       <= REG_WDATA[DIGITAL_GAIN_BIT];          // (RULE5)
			phase_comp_on         <= REG_WDATA[PHASE_COMP_BIT];            // (RULE6)
			mod_sel               <= mod_sel_t'(REG_WDATA[MOD_SEL_HI:MOD_SEL_LO]); // (RULE7)
			neg_sideband          <= REG_WDATA[NEG_SIDEBAND_BIT];          // (RULE8)
			inphase_to_quad_route <= REG_WDATA[ROUTE_BIT];                 // (RULE9)
		end
	end

	// ************************************************************
	// readback
	// ************************************************************
	// reserved and unmapped bits answer zero, never stale data
	always_comb begin
		format_word                    = 8'h00;
		format_word[OFFSET_BINARY_BIT] = offset_binary; // (RULE12)
		feature_word                   = 8'h00;
		feature_word[INVERSE_SINC_BIT] = inverse_sinc_on;
		feature_word[DIGITAL_GAIN_BIT] = digital_gain_on;
		feature_word[PHASE_COMP_BIT]   = phase_comp_on;
		feature_word[MOD_SEL_HI:MOD_SEL_LO] = mod_sel;
		feature_word[NEG_SIDEBAND_BIT] = neg_sideband;
		feature_word[ROUTE_BIT]        = inphase_to_quad_route;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				unique case (rd_sel)
					REG_CAL_INIT: REG_RDATA <= cal_init_code;
					REG_FORMAT:   REG_RDATA <= format_word;
					REG_FEATURE:  REG_RDATA <= feature_word;
					REG_NONE:     REG_RDATA <= 8'h00;
				endcase
			end
		end
	end

	// ************************************************************
	// calibration hooks
	// ************************************************************
	// start bit is written on this clock, so no synchroniser
	logic        start_rise;

	// a start bit held high launches only once
	assign start_rise = CAL_START_BIT && !start_prev; // (RULE11)

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			start_prev      <= 1'b0;
			CAL_LAUNCH      <= 1'b0;
			CAL_LAUNCH_PAGE <= '0;
		end else begin
			start_prev <= CAL_START_BIT;
			CAL_LAUNCH <= start_rise; // (RULE11)
			if (start_rise) begin
				CAL_LAUNCH_PAGE <= CAL_PAGE; // (RULE11)
			end
		end
	end

	// engine may check this flag; a wrong code is not blocked here
	assign CAL_INIT_READY  = (cal_init_code == CAL_INIT_CODE_GO); // (RULE1)
	assign CAL_INIT_VALUE  = cal_init_code;
	assign CAL_COEFF_APPLY = CAL_ENABLE_BIT; // (RULE10)

	// ************************************************************
	// feature outputs and datapath tail
	// ************************************************************
	assign INVERSE_SINC_ON = inverse_sinc_on; // (RULE4)
	assign DIGITAL_GAIN_ON = digital_gain_on; // (RULE5)
	assign PHASE_COMP_ON   = phase_comp_on;   // (RULE6)
	assign MOD_SELECT      = mod_sel;         // (RULE7)

	assign ctrl.offset_binary         = offset_binary;
	assign ctrl.inphase_to_quad_route = inphase_to_quad_route;
	assign ctrl.neg_sideband          = neg_sideband;
	assign ctrl.mod_sel               = mod_sel;

	// sideband and routing act in the tail, after format conversion
	dp_tail_stage #(
		.SAMPLE_W (SAMPLE_W),
		.TW_W     (TW_W)
	) u_tail (
		.clock     (CLOCK),
		.rst_b     (RST_B),
		.ctrl      (ctrl.stage),
		.in_valid  (SAMPLE_VALID),
		.in_i      (SAMPLE_I),
		.in_q      (SAMPLE_Q),
		.tw_in     (TUNING_WORD),
		.out_valid (DAC_VALID),
		.out_i     (DAC_I),
		.out_q     (DAC_Q),
		.tw_out    (TUNING_WORD_EFF)
	);

endmodule : dac_datapath_control_regs

// >>> bench/dac_datapath_control_regs_checker.sv
`timescale 1ns/1ps
module dac_datapath_control_regs_checker
	import dac_ctrl_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int TW_W     = 48,
	parameter int PAGE_W   = 4
) (
	input wire logic              CLOCK,
	input wire logic              RST_B,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic              REG_WR,
	input wire logic [REG_W-1:0]  REG_WDATA,
	input wire logic              REG_RD,
	input wire logic [REG_W-1:0]  REG_RDATA,
	input wire logic              REG_RVALID,
	input wire logic              CAL_ENABLE_BIT,
	input wire logic              CAL_START_BIT,
	input wire logic [PAGE_W-1:0] CAL_PAGE,
	input wire logic              CAL_LAUNCH,
	input wire logic [PAGE_W-1:0] CAL_LAUNCH_PAGE,
	input wire logic              CAL_COEFF_APPLY,
	input wire logic              CAL_INIT_READY,
	input wire logic [REG_W-1:0]  CAL_INIT_VALUE,
	input wire logic              INVERSE_SINC_ON,
	input wire logic              DIGITAL_GAIN_ON,
	input wire logic              PHASE_COMP_ON,
	input wire logic [1:0]        MOD_SELECT,
	input wire logic              SAMPLE_VALID,
	input wire logic              DAC_VALID,
	input wire logic [TW_W-1:0]   TUNING_WORD,
	input wire logic [TW_W-1:0]   TUNING_WORD_EFF
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	// ************************************************************
	// sequences and properties
	// ************************************************************
	sequence s_start_rise;
		!CAL_START_BIT ##1 CAL_START_BIT;
	endsequence
	sequence s_wr_feature;
		REG_WR && REG_ADDR == FEATURE_CTRL_ADDR;
	endsequence

	property p_launch;
		s_start_rise |=> CAL_LAUNCH && CAL_LAUNCH_PAGE == $past(CAL_PAGE);
	endproperty
	property p_feature;
		s_wr_feature |=> {INVERSE_SINC_ON, DIGITAL_GAIN_ON, PHASE_COMP_ON, MOD_SELECT}
			== {$past(REG_WDATA[7]), $past(REG_WDATA[5]), $past(REG_WDATA[4:2])};
	endproperty
	// reset is synchronous, so the attempt must not be disabled by it
	property p_reset;
		disable iff (1'b0)
		!RST_B |=> CAL_INIT_VALUE == CAL_INIT_CODE_RST && INVERSE_SINC_ON && DIGITAL_GAIN_ON
			&& !PHASE_COMP_ON && MOD_SELECT == 2'h0;
	endproperty

	property p_rvalid;
		REG_RD |=> REG_RVALID;
	endproperty
	property p_cal_wr;
		REG_WR && REG_ADDR == CAL_INIT_CODE_ADDR |=> CAL_INIT_VALUE == $past(REG_WDATA);
	endproperty
	property p_hold;
		!REG_WR |=> $stable(CAL_INIT_VALUE) && $stable(MOD_SELECT);
	endproperty
	property p_ready;
		CAL_INIT_READY == (CAL_INIT_VALUE == CAL_INIT_CODE_GO);
	endproperty
	property p_coeff;
		CAL_COEFF_APPLY == CAL_ENABLE_BIT;
	endproperty
	property p_tw;
		MOD_SELECT != 2'h1 |=> TUNING_WORD_EFF == $past(TUNING_WORD);
	endproperty
	property p_dvalid;
		SAMPLE_VALID |=> DAC_VALID;
	endproperty
	property p_rsvd_format;
		REG_RD && REG_ADDR == SAMPLE_FORMAT_ADDR |=> REG_RDATA[6:0] == 7'h00;
	endproperty
	property p_rsvd_feature;
		REG_RD && REG_ADDR == FEATURE_CTRL_ADDR |=> !REG_RDATA[6];
	endproperty

	a_launch: assert property (p_launch) else $error("calibration launch missing");
	a_feature: assert property (p_feature) else $error("feature outputs wrong");
	a_reset: assert property (p_reset) else $error("reset values wrong");
	a_rvalid: assert property (p_rvalid)
		else $error("read valid missing");
	a_cal_wr: assert property (p_cal_wr)
		else $error("init code not written");
	a_hold: assert property (p_hold)
		else $error("register changed without write");
	a_ready: assert property (p_ready)
		else $error("init ready flag wrong");
	a_coeff: assert property (p_coeff)
		else $error("coefficient apply wrong");
	a_tw: assert property (p_tw)
		else $error("tuning word altered outside fine mode");
	a_dvalid: assert property (p_dvalid)
		else $error("dac valid missing");
	a_rsvd_format: assert property (p_rsvd_format)
		else $error("format reserved bits not zero");
	a_rsvd_feature: assert property (p_rsvd_feature)
		else $error("feature reserved bit not zero");
endmodule : dac_datapath_control_regs_checker

bind dac_datapath_control_regs dac_datapath_control_regs_checker #(.SAMPLE_W(SAMPLE_W),
	.TW_W(TW_W), .PAGE_W(PAGE_W)) u_chk (.CLOCK, .RST_B, .REG_ADDR, .REG_WR, .REG_WDATA,
	.REG_RD, .REG_RDATA, .REG_RVALID, .CAL_ENABLE_BIT, .CAL_START_BIT, .CAL_PAGE, .CAL_LAUNCH,
	.CAL_LAUNCH_PAGE, .CAL_COEFF_APPLY, .CAL_INIT_READY, .CAL_INIT_VALUE, .INVERSE_SINC_ON,
	.DIGITAL_GAIN_ON, .PHASE_COMP_ON, .MOD_SELECT, .SAMPLE_VALID, .DAC_VALID, .TUNING_WORD,
	.TUNING_WORD_EFF);

// >>> bench/dac_datapath_control_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module dac_datapath_control_regs_tb_top
	import dac_ctrl_pkg::*;
;
	logic        CLOCK, RST_B, REG_WR, REG_RD, CAL_ENABLE_BIT, CAL_START_BIT, SAMPLE_VALID;
	logic        REG_RVALID, CAL_LAUNCH, CAL_COEFF_APPLY, CAL_INIT_READY, DAC_VALID;
	logic        INVERSE_SINC_ON, DIGITAL_GAIN_ON, PHASE_COMP_ON;
	logic [11:0] REG_ADDR;
	logic [7:0]  REG_WDATA, REG_RDATA, CAL_INIT_VALUE;
	logic [3:0]  CAL_PAGE, CAL_LAUNCH_PAGE;
	logic [1:0]  MOD_SELECT;
	logic [15:0] SAMPLE_I, SAMPLE_Q, DAC_I, DAC_Q;
	logic [47:0] TUNING_WORD, TUNING_WORD_EFF;
	int          err_count, n_tests;
	logic [4:0]  feat_outs;

	assign feat_outs = {INVERSE_SINC_ON, DIGITAL_GAIN_ON, PHASE_COMP_ON, MOD_SELECT};

	dac_datapath_control_regs u_dut (.CLOCK, .RST_B, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
		.REG_RDATA, .REG_RVALID, .CAL_ENABLE_BIT, .CAL_START_BIT, .CAL_PAGE, .CAL_LAUNCH,
		.CAL_LAUNCH_PAGE, .CAL_COEFF_APPLY, .CAL_INIT_READY, .CAL_INIT_VALUE, .INVERSE_SINC_ON,
		.DIGITAL_GAIN_ON, .PHASE_COMP_ON, .MOD_SELECT, .SAMPLE_VALID, .SAMPLE_I, .SAMPLE_Q,
		.TUNING_WORD, .DAC_VALID, .DAC_I, .DAC_Q, .TUNING_WORD_EFF);

	// ************************************************************
	// bus and sample tasks
	// ************************************************************
	// strobes are dropped then an edge passes, so back-to-back calls never collide
	task step; @(posedge CLOCK); #1; endtask : step
	task wr(input logic [11:0] a, input logic [7:0] d);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		step();
		REG_WR = 1'b0;
		step();
	endtask : wr
	task rd(input logic [11:0] a, input logic [7:0] e);
		REG_ADDR = a;
		REG_RD = 1'b1;
		step();
		REG_RD = 1'b0;
		`CHK("read valid", 1'b1, REG_RVALID)
		`CHK("read data", e, REG_RDATA)
		step();
	endtask : rd
	task sample(input logic [15:0] i, q, ei, eq);
		SAMPLE_I = i;
		SAMPLE_Q = q;
		SAMPLE_VALID = 1'b1;
		step();
		SAMPLE_VALID = 1'b0;
		`CHK("dac valid", 1'b1, DAC_VALID)
		`CHK("dac i", ei, DAC_I)
		`CHK("dac q", eq, DAC_Q)
		step();
	endtask : sample

	// ************************************************************
	// scenarios
	// ************************************************************
	task t_reset;
		`CHK("feature outs", 5'b11000, feat_outs)
		rd(CAL_INIT_CODE_ADDR, 8'ha6);
		rd(SAMPLE_FORMAT_ADDR, 8'h00);
		rd(FEATURE_CTRL_ADDR, 8'ha0);
	endtask : t_reset
	task t_regs;
		wr(CAL_INIT_CODE_ADDR, 8'ha2);
		`CHK("init ready", 1'b1, CAL_INIT_READY)
		rd(CAL_INIT_CODE_ADDR, 8'ha2);
		wr(SAMPLE_FORMAT_ADDR, 8'hff);
		rd(SAMPLE_FORMAT_ADDR, 8'h80);
		wr(FEATURE_CTRL_ADDR, 8'h50);
		rd(FEATURE_CTRL_ADDR, 8'h10);
		`CHK("feature outs", 5'b00100, feat_outs)
		wr(12'h112, 8'hff);
		rd(12'h112, 8'h00);
		wr(CAL_INIT_CODE_ADDR, 8'h5c);
		`CHK("init ready", 1'b0, CAL_INIT_READY)
	endtask : t_regs
	task t_modes;
		logic [47:0] e;
		TUNING_WORD = 48'h0123_4567_89ab;
		for (int m = 0; m < 4; m++) begin
			wr(FEATURE_CTRL_ADDR, {4'h0, 2'(m), 2'b10});
			e = (m == 1) ? (~TUNING_WORD + 48'h1) : TUNING_WORD;
			`CHK("mod select", 2'(m), MOD_SELECT)
			`CHK("tuning word", e, TUNING_WORD_EFF)
		end
		wr(FEATURE_CTRL_ADDR, 8'h04);
		`CHK("fine no invert", TUNING_WORD, TUNING_WORD_EFF)
	endtask : t_modes
	task t_data;
		wr(SAMPLE_FORMAT_ADDR, 8'h80);
		wr(FEATURE_CTRL_ADDR, 8'h01);
		sample(16'h8001, 16'h1234, 16'h0001, 16'h0001);
		wr(SAMPLE_FORMAT_ADDR, 8'h00);
		wr(FEATURE_CTRL_ADDR, 8'h00);
		sample(16'h8001, 16'h1234, 16'h8001, 16'h1234);
	endtask : t_data
	task t_cal;
		CAL_PAGE = 4'h5;
		CAL_START_BIT = 1'b1;
		step();
		`CHK("launch", 1'b1, CAL_LAUNCH)
		`CHK("launch page", 4'h5, CAL_LAUNCH_PAGE)
		step();
		`CHK("no relaunch", 1'b0, CAL_LAUNCH)
		CAL_START_BIT = 1'b0;
		CAL_ENABLE_BIT = 1'b1;
		#1;
		`CHK("coeff apply", 1'b1, CAL_COEFF_APPLY)
		step();
	endtask : t_cal
	task t_rst_again;
		RST_B = 1'b0;
		repeat (3) step();
		RST_B = 1'b1;
		`CHK("launch page", 4'h0, CAL_LAUNCH_PAGE)
		t_reset();
	endtask : t_rst_again

	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	// the whole sequence needs well under 200 cycles
	initial begin
		repeat (2000) @(posedge CLOCK);
		err_count++;
		test_done();
	end
	initial begin
		{RST_B, REG_WR, REG_RD, CAL_ENABLE_BIT, CAL_START_BIT, SAMPLE_VALID} = 6'h0;
		{REG_ADDR, REG_WDATA, CAL_PAGE, SAMPLE_I, SAMPLE_Q, TUNING_WORD} = 104'h0;
		err_count = 0;
		n_tests = 0;
		repeat (3) @(posedge CLOCK);
		#1;
		RST_B = 1'b1;
		t_reset();
		t_regs();
		t_modes();
		t_data();
		t_cal();
		t_rst_again();
		test_done();
	end
endmodule : dac_datapath_control_regs_tb_top
